// *** hdl/system_option_regs.v ***
// System option registers, part identification and watchdog glue of the core.
// Overview of operation
// - First options register takes only its first write after any reset.
// - First options register always reads back its present contents.
// - Two-bit timeout field with clock select sets the watchdog period.
// - Stop attempt with stop disabled forces an illegal-opcode reset.
// - Two-wire pin select: clear port A pins 2/3, set port B 6/7.
// - Debug pin enable picks debug or output-only function; set after every reset.
// - Reset pin enable cleared by power-on only, kept by other resets.
// - Reset pin enable turns on the reset pin pull-up.
// - Bit 4 of first options stores writes without any effect.
// - Watchdog clock select: clear slow 1 kHz tick, set bus clock.
// - Window mode: refresh only in last quarter; earlier writes reset.
// - Window mode works only when watchdog clock select is one.
// - Comparator-to-capture bit routes comparator output to timer input 0.
// - Timer channel 1 pin: clear port B pin 5, set port C pin 1.
// - Timer channel 0 pin: clear port A pin 0, set port C pin 0.
// - Write-once bits of second options take one write per reset.
// - Identification registers are read-only and hold a fixed 12-bit number.
// - High identification bits 7:4 read zero, bits 3:0 hold the top of the number, writes ignored.
// - Refresh is 0x55 then 0xAA; other values reset while enabled.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "sysopt_defines.vh"

module system_option_regs #(
    parameter [11:0] PART_NUMBER = 12'h5A3,
    parameter integer SLOW_DIV   = `SLOW_DIV_CYCLES
) (
    // Clock and resets
    input  wire        CLOCK_I,
    input  wire        ARST_N_I,
    input  wire        POR_N_I,
    // Register port
    input  wire [2:0]  ADDR_I,
    input  wire [7:0]  WDATA_I,
    input  wire        WR_I,
    input  wire        RD_I,
    output reg  [7:0]  RDATA_O,
    // Core events
    input  wire        STOP_REQ_I,
    input  wire        CMP_OUT_I,
    // Event pulses and configuration outputs
    output reg         STOP_ENTER_O,
    output reg         ILLEGAL_RESET_O,
    output reg         WDOG_RESET_O,
    output reg         TWOWIRE_ON_PORTB_O,
    output reg         DEBUG_PIN_FUNCTION_O,
    output reg         RESET_PIN_FUNCTION_O,
    output reg         RESET_PULLUP_EN_O,
    output reg         CAPTURE0_FROM_CMP_O,
    output reg         CAPTURE0_IN_O,
    output reg         CH1_ON_PORTC_O,
    output reg         CH0_ON_PORTC_O
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function [5:0] period_bits;
        input [1:0] sel;
        begin
            case (sel)
                2'h1: period_bits = `WDOG_PERIOD_SHORT;
                2'h2: period_bits = `WDOG_PERIOD_MID;
                2'h3: period_bits = `WDOG_PERIOD_LONG;
                default: period_bits = 6'h0;
            endcase
        end
    endfunction

    function addr_hit;
        input [2:0] addr;
        input [2:0] idx;
        begin
            addr_hit = (addr == idx);
        end
    endfunction

    wire wr_first  = WR_I && addr_hit(ADDR_I, `ADDR_OPTS_FIRST);
    wire wr_second = WR_I && addr_hit(ADDR_I, `ADDR_OPTS_SECOND);
    wire wr_status = WR_I && addr_hit(ADDR_I, `ADDR_RESET_STATUS);

    // ****************************************************************
    // First options register
    // ****************************************************************
    reg  [7:0] opts1_r;
    reg        opts1_done_r;
    reg        reset_en_r;

    // The reset pin bit lives in its own flop, cleared only by power-on,
    // so internal resets do not drop an active external reset pin.
    always @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            opts1_r      <= `F1_RESET_VAL & 8'hFE;
            opts1_done_r <= 1'b0;
        end else if (wr_first && !opts1_done_r) begin
            opts1_r      <= WDATA_I & `F1_IMPL_MASK & 8'hFE;
            opts1_done_r <= 1'b1;
        end
    end

    always @(posedge CLOCK_I or negedge POR_N_I) begin
        if (!POR_N_I) begin
            reset_en_r <= 1'b0;
        end else if (wr_first && !opts1_done_r) begin
            reset_en_r <= WDATA_I[`F1_RESET_EN];
        end
    end

    // ****************************************************************
    // Second options register
    // ****************************************************************
    reg  [7:0] opts2_r;
    reg        opts2_done_r;

    always @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            opts2_r      <= `F2_RESET_VAL;
            opts2_done_r <= 1'b0;
        end else if (wr_second) begin
            opts2_r <= opts2_done_r ?
                       ((opts2_r & `F2_ONCE_MASK) | (WDATA_I & `F2_IMPL_MASK & ~`F2_ONCE_MASK)) :
                       (WDATA_I & `F2_IMPL_MASK);
            opts2_done_r <= 1'b1;
        end
    end

    // ****************************************************************
    // Watchdog timing
    // ****************************************************************
    reg  [14:0] slow_div_r;
    reg         slow_tick_r;
    reg  [31:0] wdog_cnt_r;
    reg         key_armed_r;

    always @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            slow_div_r  <= 15'h0;
            slow_tick_r <= 1'b0;
        end else if (slow_div_r == SLOW_DIV[14:0] - 15'h1) begin
            slow_div_r  <= 15'h0;
            slow_tick_r <= 1'b1;
        end else begin
            slow_div_r  <= slow_div_r + 15'h1;
            slow_tick_r <= 1'b0;
        end
    end

    wire [5:0]  per_bits  = period_bits(opts1_r[`F1_TIMEOUT_HI:`F1_TIMEOUT_LO]);
    wire        wdog_on   = (per_bits != 6'h0);
    wire        wdog_step = opts2_r[`F2_WDOG_CLK] ? 1'b1 : slow_tick_r;
    wire [31:0] period    = 32'h1 << per_bits;
    wire        window_on = opts2_r[`F2_WINDOW] && opts2_r[`F2_WDOG_CLK];
    wire        in_open   = (wdog_cnt_r >= period - (period >> 2));
    wire        expired   = wdog_on && wdog_step && (wdog_cnt_r >= period - 32'h1);
    wire        good_key2 = wr_status && key_armed_r && (WDATA_I == `WDOG_KEY_SECOND);
    wire        good_key1 = wr_status && (WDATA_I == `WDOG_KEY_FIRST);
    wire        early_wr  = window_on && wr_status && !in_open;
    wire        bad_key   = wr_status && !good_key1 && !good_key2;
    wire        wdog_fire = wdog_on && (expired || bad_key || early_wr);

    always @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wdog_cnt_r  <= 32'h0;
            key_armed_r <= 1'b0;
        end else begin
            if (wr_status) begin
                key_armed_r <= good_key1;
            end
            if (good_key2 && !early_wr) begin
                wdog_cnt_r <= 32'h0;
            end else if (wdog_on && wdog_step) begin
                wdog_cnt_r <= wdog_cnt_r + 32'h1;
            end
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    always @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RDATA_O <= 8'h00;
        end else if (RD_I) begin
            case (ADDR_I)
                `ADDR_OPTS_FIRST:  RDATA_O <= opts1_r | {7'h0, reset_en_r};
                `ADDR_OPTS_SECOND: RDATA_O <= opts2_r;
                `ADDR_IDENT_HIGH:  RDATA_O <= {4'h0, PART_NUMBER[11:8]};
                `ADDR_IDENT_LOW:   RDATA_O <= PART_NUMBER[7:0];
                default:           RDATA_O <= 8'h00;
            endcase
        end else begin
            RDATA_O <= 8'h00;
        end
    end

    // ****************************************************************
    // Core event pulses
    // ****************************************************************
    // Outputs follow their cause one cycle later and stay high while it lasts, e.g. a held stop request or an expired bus-clocked watchdog.
    // stop accepted
    always @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            STOP_ENTER_O <= 1'b0;
        end else begin
            STOP_ENTER_O <= STOP_REQ_I && opts1_r[`F1_STOP_EN];
        end
    end

    always @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ILLEGAL_RESET_O <= 1'b0;
        end else begin
            ILLEGAL_RESET_O <= STOP_REQ_I && !opts1_r[`F1_STOP_EN];
        end
    end

    always @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            WDOG_RESET_O <= 1'b0;
        end else begin
            WDOG_RESET_O <= wdog_fire;
        end
    end

    // ****************************************************************
    // Pin routing
    // ****************************************************************
    // two-wire pins
    always @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            TWOWIRE_ON_PORTB_O <= 1'b0;
        end else begin
            TWOWIRE_ON_PORTB_O <= opts1_r[`F1_TWOWIRE];
        end
    end

    always @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            DEBUG_PIN_FUNCTION_O <= 1'b1;
        end else begin
            DEBUG_PIN_FUNCTION_O <= opts1_r[`F1_DEBUG_EN];
        end
    end

    always @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CAPTURE0_FROM_CMP_O <= 1'b0;
        end else begin
            CAPTURE0_FROM_CMP_O <= opts2_r[`F2_CMP_CAPTURE];
        end
    end

    always @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CAPTURE0_IN_O <= 1'b0;
        end else begin
            CAPTURE0_IN_O <= opts2_r[`F2_CMP_CAPTURE] && CMP_OUT_I;
        end
    end

    always @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CH1_ON_PORTC_O <= 1'b0;
        end else begin
            CH1_ON_PORTC_O <= opts2_r[`F2_CH1_PIN];
        end
    end

    always @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CH0_ON_PORTC_O <= 1'b0;
        end else begin
            CH0_ON_PORTC_O <= opts2_r[`F2_CH0_PIN];
        end
    end

    // ****************************************************************
    // Reset pin function
    // ****************************************************************
    // These outputs live in the power-on domain, so an internal reset
    // never drops an external reset pin that software has turned on.
    // kept over internal resets
    always @(posedge CLOCK_I or negedge POR_N_I) begin
        if (!POR_N_I) begin
            RESET_PIN_FUNCTION_O <= 1'b0;
        end else begin
            RESET_PIN_FUNCTION_O <= reset_en_r;
        end
    end

    always @(posedge CLOCK_I or negedge POR_N_I) begin
        if (!POR_N_I) begin
            RESET_PULLUP_EN_O <= 1'b0;
        end else begin
            RESET_PULLUP_EN_O <= reset_en_r;
        end
    end

endmodule // system_option_regs

// *** inc/sysopt_defines.vh ***
// Offsets, field positions, reset values and timing counts of the system option registers.
`ifndef SYSOPT_DEFINES_VH
`define SYSOPT_DEFINES_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_OPTS_FIRST     3'h0
`define ADDR_OPTS_SECOND    3'h1
`define ADDR_IDENT_HIGH     3'h2
`define ADDR_IDENT_LOW      3'h3
`define ADDR_RESET_STATUS   3'h4

// ****************************************************************
// First options fields
// ****************************************************************
`define F1_TIMEOUT_HI       7
`define F1_TIMEOUT_LO       6
`define F1_STOP_EN          5
`define F1_SPARE            4
`define F1_TWOWIRE          2
`define F1_DEBUG_EN         1
`define F1_RESET_EN         0
`define F1_RESET_VAL        8'hC2
`define F1_IMPL_MASK        8'hF7

// ****************************************************************
// Second options fields
// ****************************************************************
`define F2_WDOG_CLK         7
`define F2_WINDOW           6
`define F2_CMP_CAPTURE      4
`define F2_CH1_PIN          1
`define F2_CH0_PIN          0
`define F2_RESET_VAL        8'h00
`define F2_IMPL_MASK        8'hD3
`define F2_ONCE_MASK        8'hC0

// ****************************************************************
// Watchdog
// ****************************************************************
`define WDOG_KEY_FIRST      8'h55
`define WDOG_KEY_SECOND     8'hAA
`define CLK_HZ              25000000
`define SLOW_CLK_HZ         1000
`define SLOW_DIV_CYCLES     (`CLK_HZ / `SLOW_CLK_HZ)
`define WDOG_PERIOD_SHORT   6'h05
`define WDOG_PERIOD_MID     6'h08
`define WDOG_PERIOD_LONG    6'h0A

`endif

// *** verif/system_option_regs_sva.sv ***
// Port assertions of the system option registers.
`timescale 1ns/1ps
`include "sysopt_defines.vh"
module system_option_regs_chk #(
    parameter [11:0] PART_NUMBER = 12'h5A3
) (
    input wire       CLOCK_I,
    input wire       ARST_N_I,
    input wire [2:0] ADDR_I,
    input wire       WR_I,
    input wire       RD_I,
    input wire [7:0] RDATA_O,
    input wire       STOP_REQ_I,
    input wire       CMP_OUT_I,
    input wire       STOP_ENTER_O,
    input wire       ILLEGAL_RESET_O,
    input wire       DEBUG_PIN_FUNCTION_O,
    input wire       RESET_PIN_FUNCTION_O,
    input wire       RESET_PULLUP_EN_O,
    input wire       CAPTURE0_IN_O,
    input wire       CH0_ON_PORTC_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!ARST_N_I);
    wire wr_two = WR_I && (ADDR_I == `ADDR_OPTS_SECOND);
    sequence rd_high; RD_I && (ADDR_I == `ADDR_IDENT_HIGH); endsequence
    sequence rd_low; RD_I && (ADDR_I == `ADDR_IDENT_LOW); endsequence
    AST_ID_HIGH: assert property (rd_high |=> RDATA_O == {4'h0, PART_NUMBER[11:8]})
        else $error("High ident read wrong.");
    AST_ID_LOW: assert property (rd_low |=> RDATA_O == PART_NUMBER[7:0])
        else $error("Low ident read wrong.");
    AST_RD_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("Read data outside read slot.");
    AST_PULLUP: assert property (RESET_PULLUP_EN_O == RESET_PIN_FUNCTION_O)
        else $error("Pull-up does not follow reset pin.");
    AST_STOP: assert property (STOP_REQ_I |=> STOP_ENTER_O != ILLEGAL_RESET_O)
        else $error("Stop attempt gave no single outcome.");
    AST_STOP_CAUSE: assert property ((STOP_ENTER_O || ILLEGAL_RESET_O) |-> $past(STOP_REQ_I))
        else $error("Stop outcome without attempt.");
    AST_CAPTURE: assert property (CAPTURE0_IN_O |-> $past(CMP_OUT_I))
        else $error("Capture input without comparator.");
    AST_DEBUG: assert property ($rose(ARST_N_I) |-> DEBUG_PIN_FUNCTION_O)
        else $error("Debug pin not set after reset.");
    AST_CH0: assert property ($changed(CH0_ON_PORTC_O) |-> $past(wr_two) || $past(wr_two, 2))
        else $error("Channel 0 pin moved without a write.");
endmodule // system_option_regs_chk

bind system_option_regs system_option_regs_chk #(.PART_NUMBER(PART_NUMBER)) u_chk (
    .CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
    .RDATA_O(RDATA_O), .STOP_REQ_I(STOP_REQ_I), .CMP_OUT_I(CMP_OUT_I),
    .STOP_ENTER_O(STOP_ENTER_O), .ILLEGAL_RESET_O(ILLEGAL_RESET_O),
    .DEBUG_PIN_FUNCTION_O(DEBUG_PIN_FUNCTION_O), .RESET_PIN_FUNCTION_O(RESET_PIN_FUNCTION_O),
    .RESET_PULLUP_EN_O(RESET_PULLUP_EN_O), .CAPTURE0_IN_O(CAPTURE0_IN_O),
    .CH0_ON_PORTC_O(CH0_ON_PORTC_O));

// *** verif/system_option_regs_tb.sv ***
// Self-checking testbench of the system option registers.
`timescale 1ns/1ps
`include "sysopt_defines.vh"
module system_option_regs_tb;
    // Part number value is arbitrary.
    localparam [11:0] PN = 12'h3C9;
    reg        clk = 1'b0, arst_n = 1'b0, por_n = 1'b0, wr = 1'b0, rd = 1'b0;
    reg        stop_req = 1'b0, cmp = 1'b0;
    reg  [2:0] addr = 3'h0;
    reg  [7:0] wdata = 8'h00, got, v, w, w2;
    wire [7:0] rdata;
    wire       s_ent, ill, wdg, tw, dbg, rpin, pu, csel, cin, ch1, ch0;
    integer    fails = 0, checks = 0, i;
    system_option_regs #(.PART_NUMBER(PN), .SLOW_DIV(4)) dut (
        .CLOCK_I(clk), .ARST_N_I(arst_n), .POR_N_I(por_n), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .STOP_REQ_I(stop_req),
        .CMP_OUT_I(cmp), .STOP_ENTER_O(s_ent), .ILLEGAL_RESET_O(ill), .WDOG_RESET_O(wdg),
        .TWOWIRE_ON_PORTB_O(tw), .DEBUG_PIN_FUNCTION_O(dbg), .RESET_PIN_FUNCTION_O(rpin),
        .RESET_PULLUP_EN_O(pu), .CAPTURE0_FROM_CMP_O(csel), .CAPTURE0_IN_O(cin),
        .CH1_ON_PORTC_O(ch1), .CH0_ON_PORTC_O(ch0));
    initial forever #20 clk = ~clk;
    // Locked bits keep the first value, the rest follow the latest write.
    function [7:0] exp2(input [7:0] a, input [7:0] b);
        exp2 = (a & `F2_ONCE_MASK) | (b & `F2_IMPL_MASK & ~`F2_ONCE_MASK);
    endfunction
    task chk(input [7:0] g, input [7:0] e);
        begin
            checks = checks + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task wr_reg(input [2:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_chk(input [2:0] a, input [7:0] e);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk(rdata, e);
        end
    endtask
    // Pulses are collected over four cycles, though each output follows its cause one cycle later.
    task watch(output [7:0] s);
        begin
            s = 8'h00;
            repeat (4) begin
                #1 s = s | {5'h0, wdg, ill, s_ent};
                @(posedge clk);
            end
        end
    endtask
    task do_reset(input p);
        begin
            @(posedge clk);
            arst_n <= 1'b0;
            por_n <= ~p;
            repeat (10) @(posedge clk);
            arst_n <= 1'b1;
            por_n <= 1'b1;
        end
    endtask
    task finish_test;
        begin
            $display("checks=%0d fails=%0d", checks, fails);
            if (fails == 0 && checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        #400000;
        fails = fails + 1;
        finish_test;
    end
    initial begin
        i = $urandom(32'h3250fed3);
        for (i = 0; i < 2; i = i + 1) begin
            do_reset(1'b1);
            rd_chk(`ADDR_OPTS_FIRST, `F1_RESET_VAL);
            rd_chk(`ADDR_OPTS_SECOND, `F2_RESET_VAL);
            chk({7'h0, dbg}, 8'h01);
            v = 8'($urandom);
            v[5] = i[0];
            v[7:6] = 2'b01;
            wr_reg(`ADDR_OPTS_FIRST, v);
            wr_reg(`ADDR_OPTS_FIRST, ~v);
            rd_chk(`ADDR_OPTS_FIRST, v & `F1_IMPL_MASK);
            repeat (2) @(posedge clk);
            #1 chk({4'h0, tw, dbg, rpin, pu}, {4'h0, v[2], v[1], v[0], v[0]});
            @(posedge clk) stop_req <= 1'b1;
            @(posedge clk) stop_req <= 1'b0;
            watch(got);
            chk(got & 8'h03, {6'h0, ~v[5], v[5]});
            wr_reg(`ADDR_RESET_STATUS, `WDOG_KEY_FIRST);
            wr_reg(`ADDR_RESET_STATUS, `WDOG_KEY_SECOND);
            watch(got);
            chk(got & 8'h04, 8'h00);
            wr_reg(`ADDR_RESET_STATUS, 8'h3C);
            watch(got);
            chk(got & 8'h04, 8'h04);
            repeat (130) @(posedge clk);
            watch(got);
            chk(got & 8'h04, 8'h04);
            w = 8'($urandom);
            w2 = 8'($urandom);
            cmp <= w2[3];
            wr_reg(`ADDR_OPTS_SECOND, w);
            wr_reg(`ADDR_OPTS_SECOND, w2);
            rd_chk(`ADDR_OPTS_SECOND, exp2(w, w2));
            repeat (2) @(posedge clk);
            #1 chk({4'h0, cin, csel, ch1, ch0}, {4'h0, w2[4] & w2[3], w2[4], w2[1], w2[0]});
            wr_reg(`ADDR_IDENT_HIGH, 8'($urandom));
            wr_reg(`ADDR_IDENT_LOW, 8'($urandom));
            rd_chk(`ADDR_IDENT_HIGH, {4'h0, PN[11:8]});
            rd_chk(`ADDR_IDENT_LOW, PN[7:0]);
            rd_chk(3'h7, 8'h00);
            do_reset(1'b0);
            rd_chk(`ADDR_OPTS_FIRST, `F1_RESET_VAL | (v & 8'h01));
            chk({6'h0, rpin, pu}, {6'h0, v[0], v[0]});
            $display("test %0d done", i);
        end
        finish_test;
    end
endmodule // system_option_regs_tb
